// ===== hdl/acpc_regs.sv
`timescale 1ns/1ns
module acpc_regs
    import acpc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register port from serial control interface
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [REG_AW-1:0] regAddr,
    input wire logic [REG_DW-1:0] regWrData,
    output logic [REG_DW-1:0] regRdData,
    // control bits held elsewhere
    input wire logic patternCheckOn,
    input wire logic oneApartAlarmOn,
    input wire logic twoApartAlarmOn,
    input wire logic autoClearAfterGoodRun,
    // input data path
    input wire logic dataValid,
    input wire logic [REG_DW-1:0] dataByte,
    input wire logic [5*REG_DW-1:0] patternWordsHigh,
    // fifo pointers
    input wire logic fifoSync,
    input wire logic wrAdvance,
    input wire logic [PTR_W-1:0] rdPtr,
    output logic [PTR_W-1:0] wrPtr,
    // alarm pin
    output logic alarmOutputPin
);

    acpc_ptr_if ptr ();

    acpc_ptr_mon u_mon (
        .sys_clk(sys_clk),
        .rst(rst),
        .ptr(ptr)
    );

    assign ptr.fifoSync = fifoSync;
    assign ptr.wrAdvance = wrAdvance;
    assign ptr.rdPtr = rdPtr;
    assign wrPtr = ptr.wrPtr;

    logic [ALARM_W-1:0] alarmPinMask_q;
    logic [ALARM_W-1:0] alarmStatus_q;
    logic [ALARM_W-1:0] alarmStatus_d;
    logic [REG_DW-1:0] patternFail_q;
    logic [REG_DW-1:0] patternFail_d;
    logic [REG_DW-1:0] patternWord0_q;
    logic [REG_DW-1:0] patternWord1_q;
    logic [REG_DW-1:0] patternWord2_q;
    logic [PAT_IDX_W-1:0] patIdx_q;
    logic [GOOD_CNT_W-1:0] goodCnt_q;
    logic [REG_DW-1:0] rdData_q;
    logic alarmPin_q;
    logic [REG_DW-1:0] patternWords [PAT_WORDS];
    logic [REG_DW-1:0] patDiff;
    logic patCheck;
    logic [ALARM_W-1:0] events;
    logic autoClear;
    logic [PAT_WORDS*REG_DW-1:0] patternWordsAll;
    logic statusClear;
    logic failClear;

    // all eight pattern words side by side, word zero lowest
    assign patternWordsAll = {patternWordsHigh, patternWord2_q, patternWord1_q, patternWord0_q};

    // words three to seven come from their own registers elsewhere
    generate
        for (genvar w = 0; w < PAT_WORDS; w++) begin : g_words
            assign patternWords[w] = patternWordsAll[w*REG_DW +: REG_DW];
        end
    endgenerate

    // one comparison per valid sample while the checker runs
    assign patCheck = patternCheckOn && dataValid;
    assign patDiff = patCheck ? (dataByte ^ patternWords[patIdx_q]) : '0;

    always_comb begin
        events = '0;
        events[BIT_ZERO_PTR] = ptr.zeroPtr;
        events[BIT_COLLISION] = ptr.collision;
        events[BIT_PATTERN] = (patDiff != '0);
        events[BIT_TWO_APART] = twoApartAlarmOn && ptr.twoApart;
        events[BIT_ONE_APART] = oneApartAlarmOn && ptr.oneApart;
    end

    // pattern word sequence position, restarts while the checker is off
    always_ff @(posedge sys_clk) begin
        if (rst || !patternCheckOn) begin
            patIdx_q <= '0;
        end else if (dataValid) begin
            patIdx_q <= patIdx_q + 1'b1;
        end
    end

    // run of consecutive clean samples
    always_ff @(posedge sys_clk) begin
        if (rst || !autoClearAfterGoodRun || events != '0 || autoClear) begin
            goodCnt_q <= '0;
        end else if (dataValid) begin
            goodCnt_q <= goodCnt_q + 1'b1;
        end
    end

    assign autoClear = autoClearAfterGoodRun && dataValid && (events == '0) &&
        (goodCnt_q == GOOD_CNT_W'(GOOD_RUN_LEN - 1));

    // host write to the offset clears the whole register, whatever the data
    assign statusClear = (regWrEn && regAddr == ADDR_ALARM_STATUS_FLAGS) || autoClear;
    assign failClear = (regWrEn && regAddr == ADDR_PATTERN_FAIL_BITS) || autoClear;

    // a new event wins over a clear in the same cycle
    always_comb begin
        alarmStatus_d = statusClear ? '0 : alarmStatus_q;
        alarmStatus_d = (alarmStatus_d | events) & ALARM_USED;
    end

    always_comb begin
        patternFail_d = failClear ? '0 : patternFail_q;
        patternFail_d = patternFail_d | patDiff;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            alarmStatus_q <= RST_ALARM_STATUS_FLAGS;
        end else begin
            alarmStatus_q <= alarmStatus_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            patternFail_q <= RST_PATTERN_FAIL_BITS;
        end else begin
            patternFail_q <= patternFail_d;
        end
    end

    // writable registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            alarmPinMask_q <= RST_ALARM_PIN_MASK;
        end else if (regWrEn && regAddr == ADDR_ALARM_PIN_MASK) begin
            alarmPinMask_q <= regWrData[ALARM_W-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            patternWord0_q <= RST_PATTERN_WORD_ZERO;
        end else if (regWrEn && regAddr == ADDR_PATTERN_WORD_ZERO) begin
            patternWord0_q <= regWrData;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            patternWord1_q <= RST_PATTERN_WORD_ONE;
        end else if (regWrEn && regAddr == ADDR_PATTERN_WORD_ONE) begin
            patternWord1_q <= regWrData;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            patternWord2_q <= RST_PATTERN_WORD_TWO;
        end else if (regWrEn && regAddr == ADDR_PATTERN_WORD_TWO) begin
            patternWord2_q <= regWrData;
        end
    end

    // read mux, unmapped offsets read zero
    // a read in the same cycle as a write returns the old value
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdData_q <= '0;
        end else if (regRdEn) begin
            case (regAddr)
                ADDR_ALARM_PIN_MASK: rdData_q <= {1'b0, alarmPinMask_q};
                ADDR_ALARM_STATUS_FLAGS: rdData_q <= {1'b0, alarmStatus_q};
                ADDR_PATTERN_FAIL_BITS: rdData_q <= patternFail_q;
                ADDR_PATTERN_WORD_ZERO: rdData_q <= patternWord0_q;
                ADDR_PATTERN_WORD_ONE: rdData_q <= patternWord1_q;
                ADDR_PATTERN_WORD_TWO: rdData_q <= patternWord2_q;
                default: rdData_q <= '0;
            endcase
        end
    end

    assign regRdData = rdData_q;

    // registered pin, one cycle behind the status
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            alarmPin_q <= 1'b0;
        end else begin
            alarmPin_q <= |(alarmStatus_q & ~alarmPinMask_q);
        end
    end

    assign alarmOutputPin = alarmPin_q;

endmodule // acpc_regs

// ===== shared/acpc_pkg.sv
package acpc_pkg;

    localparam int REG_AW = 8;
    localparam int REG_DW = 8;
    localparam int PTR_W = 8;
    localparam int PAT_WORDS = 8;
    localparam int PAT_IDX_W = 3;
    localparam int ALARM_W = 7;

    // register offsets
    localparam logic [REG_AW-1:0] ADDR_ALARM_PIN_MASK = 8'h06;
    localparam logic [REG_AW-1:0] ADDR_ALARM_STATUS_FLAGS = 8'h07;
    localparam logic [REG_AW-1:0] ADDR_PATTERN_FAIL_BITS = 8'h08;
    localparam logic [REG_AW-1:0] ADDR_PATTERN_WORD_ZERO = 8'h09;
    localparam logic [REG_AW-1:0] ADDR_PATTERN_WORD_ONE = 8'h0a;
    localparam logic [REG_AW-1:0] ADDR_PATTERN_WORD_TWO = 8'h0b;

    // reset values
    localparam logic [ALARM_W-1:0] RST_ALARM_PIN_MASK = 7'h00;
    localparam logic [ALARM_W-1:0] RST_ALARM_STATUS_FLAGS = 7'h00;
    localparam logic [REG_DW-1:0] RST_PATTERN_FAIL_BITS = 8'h00;
    localparam logic [REG_DW-1:0] RST_PATTERN_WORD_ZERO = 8'h7a;
    localparam logic [REG_DW-1:0] RST_PATTERN_WORD_ONE = 8'hb6;
    localparam logic [REG_DW-1:0] RST_PATTERN_WORD_TWO = 8'hea;

    // alarm bit positions, shared by mask and status
    localparam int BIT_ZERO_PTR = 6;
    localparam int BIT_COLLISION = 5;
    localparam int BIT_PATTERN = 3;
    localparam int BIT_TWO_APART = 1;
    localparam int BIT_ONE_APART = 0;
    localparam logic [ALARM_W-1:0] ALARM_USED = 7'h6b;

    // write pointer value loaded by a fifo sync event
    localparam logic [PTR_W-1:0] WR_PTR_SYNC = 8'h01;

    // consecutive good samples before auto clear
    localparam int GOOD_RUN_LEN = 64;
    localparam int GOOD_CNT_W = 7;

endpackage

// ===== shared/acpc_ptr_if.sv
`timescale 1ns/1ns
interface acpc_ptr_if;
    import acpc_pkg::*;

    logic fifoSync;
    logic wrAdvance;
    logic [PTR_W-1:0] rdPtr;
    logic [PTR_W-1:0] wrPtr;
    logic zeroPtr;
    logic collision;
    logic oneApart;
    logic twoApart;

    modport regs (output fifoSync, output wrAdvance, output rdPtr,
                  input wrPtr, input zeroPtr, input collision, input oneApart, input twoApart);
    modport mon (input fifoSync, input wrAdvance, input rdPtr,
                 output wrPtr, output zeroPtr, output collision, output oneApart, output twoApart);
endinterface

// ===== hdl/acpc_ptr_mon.sv
`timescale 1ns/1ns
module acpc_ptr_mon
    import acpc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // pointer link
    acpc_ptr_if.mon ptr
);

    logic [PTR_W-1:0] wrPtr_q;
    logic [PTR_W-1:0] wrPtr_d;

    function automatic logic [PTR_W-1:0] rotUp(input logic [PTR_W-1:0] v, input int n);
        logic [2*PTR_W-1:0] dbl;
        dbl = {v, v} << n;
        return dbl[2*PTR_W-1:PTR_W];
    endfunction

    // one-hot shift; an all-zero pointer rotates into itself until sync
    always_comb begin
        wrPtr_d = wrPtr_q;
        if (ptr.fifoSync) begin
            wrPtr_d = WR_PTR_SYNC;
        end else if (ptr.wrAdvance) begin
            wrPtr_d = rotUp(wrPtr_q, 1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wrPtr_q <= WR_PTR_SYNC;
        end else begin
            wrPtr_q <= wrPtr_d;
        end
    end

    assign ptr.wrPtr = wrPtr_q;
    assign ptr.zeroPtr = (wrPtr_q == '0);
    // pointer distance tests are meaningless on an invalid pointer
    assign ptr.collision = !ptr.zeroPtr && (wrPtr_q == ptr.rdPtr);
    assign ptr.oneApart = !ptr.zeroPtr &&
        ((rotUp(wrPtr_q, 1) == ptr.rdPtr) || (rotUp(wrPtr_q, PTR_W - 1) == ptr.rdPtr));
    assign ptr.twoApart = ptr.oneApart || (!ptr.zeroPtr &&
        ((rotUp(wrPtr_q, 2) == ptr.rdPtr) || (rotUp(wrPtr_q, PTR_W - 2) == ptr.rdPtr)));

endmodule // acpc_ptr_mon

// ===== sim/acpc_regs_chk.sv
`timescale 1ns/1ns
module acpc_regs_chk
    import acpc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // watched ports
    input wire logic regRdEn,
    input wire logic [REG_AW-1:0] regAddr,
    input wire logic [REG_DW-1:0] regRdData,
    input wire logic fifoSync,
    input wire logic wrAdvance,
    input wire logic [PTR_W-1:0] wrPtr,
    input wire logic alarmOutputPin
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_sync_loads_ptr: assert property (fifoSync |=> wrPtr == WR_PTR_SYNC)
        else $error("sync did not load pointer");
    a_zero_ptr_stuck: assert property (wrPtr == 8'h00 && !fifoSync |=> wrPtr == 8'h00)
        else $error("zero pointer left without sync");
    a_ptr_hold: assert property (!fifoSync && !wrAdvance |=> $stable(wrPtr))
        else $error("pointer moved without cause");
    a_ptr_onehot: assert property ($onehot0(wrPtr))
        else $error("pointer not one-hot");
    a_unmapped_zero: assert property (regRdEn && (regAddr < 8'h06 || regAddr > 8'h0b) |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    a_rd_data_holds: assert property (!regRdEn |=> $stable(regRdData))
        else $error("read data changed without read");
    a_mask_top_zero: assert property (regRdEn && regAddr == ADDR_ALARM_PIN_MASK |=> !regRdData[7])
        else $error("mask bit 7 read high");
    a_status_resv_zero: assert property (regRdEn && regAddr == ADDR_ALARM_STATUS_FLAGS |=>
        regRdData[7] == 1'b0 && regRdData[4] == 1'b0 && regRdData[2] == 1'b0)
        else $error("unused status bit read high");
    cover property (alarmOutputPin);
    cover property (regRdEn && regAddr == ADDR_ALARM_STATUS_FLAGS);
    cover property (wrAdvance);
endmodule // acpc_regs_chk
bind acpc_regs acpc_regs_chk u_chk (.sys_clk(sys_clk), .rst(rst), .regRdEn(regRdEn), .regAddr(regAddr),
    .regRdData(regRdData), .fifoSync(fifoSync), .wrAdvance(wrAdvance), .wrPtr(wrPtr),
    .alarmOutputPin(alarmOutputPin));

// ===== sim/acpc_regs_tb.sv
`timescale 1ns/1ns
module acpc_regs_tb;
    import acpc_pkg::*;
    logic sys_clk = 1'b0, rst = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0, dataValid = 1'b0;
    logic patternCheckOn = 1'b0, oneApartAlarmOn = 1'b0, twoApartAlarmOn = 1'b0, autoClearAfterGoodRun = 1'b0;
    logic fifoSync = 1'b0, wrAdvance = 1'b0, alarmOutputPin;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, dataByte = 8'h00, rdPtr = 8'h10, regRdData, wrPtr;
    logic [39:0] patternWordsHigh = 40'hc7_c6_c5_c4_c3;
    int n_mismatch = 0, total_checks = 0, pi = 0;
    // write flag, offset, write data, expected read
    logic [24:0] rows [13] = '{25'h0_06_00_00, 25'h0_07_00_00, 25'h0_08_00_00, 25'h0_09_00_7a, 25'h0_0a_00_b6,
        25'h0_0b_00_ea, 25'h1_06_ff_7f, 25'h1_09_11_11, 25'h1_0a_22_22, 25'h1_0b_33_33, 25'h1_0c_55_00,
        25'h0_05_00_00, 25'h1_06_00_00};

    acpc_regs dut (.sys_clk, .rst, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData, .patternCheckOn,
        .oneApartAlarmOn, .twoApartAlarmOn, .autoClearAfterGoodRun, .dataValid, .dataByte, .patternWordsHigh,
        .fifoSync, .wrAdvance, .rdPtr, .wrPtr, .alarmOutputPin);

    initial forever #2 sys_clk = ~sys_clk;

    function automatic logic [7:0] wd(input int i);
        return i == 0 ? 8'h11 : i == 1 ? 8'h22 : i == 2 ? 8'h33 : (8'hc0 | 8'(i));
    endfunction

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        regWrEn = 1'b1;
        regAddr = a;
        regWrData = d;
        @(negedge sys_clk);
        regWrEn = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge sys_clk);
        regRdEn = 1'b1;
        regAddr = a;
        @(negedge sys_clk);
        regRdEn = 1'b0;
        chk(regRdData, exp);
    endtask

    // one sample, index tracked while the checker runs
    task automatic samp(input logic [7:0] d);
        @(negedge sys_clk);
        dataValid = 1'b1;
        dataByte = d;
        if (patternCheckOn) pi = (pi + 1) % 8;
        @(negedge sys_clk);
        dataValid = 1'b0;
    endtask

    initial begin
        repeat (5000) @(posedge sys_clk);
        $display("unexpected at %0t: run did not finish in time", $time);
        n_mismatch++;
        tally_and_finish;
    end

    initial begin
        cyc(16);
        rst = 1'b0;
        foreach (rows[i]) begin
            if (rows[i][24]) wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], rows[i][7:0]);
        end
        wrAdvance = 1'b1;
        cyc(3);
        chk(wrPtr, 8'h08);
        fifoSync = 1'b1;
        cyc(1);
        fifoSync = 1'b0;
        wrAdvance = 1'b0;
        chk(wrPtr, 8'h01);
        rdPtr = 8'h01;
        cyc(1);
        rdPtr = 8'h10;
        cyc(2);
        rd(8'h07, 8'h20);
        chk({7'h0, alarmOutputPin}, 8'h01);
        wr(8'h06, 8'h20);
        rd(8'h07, 8'h20);
        chk({7'h0, alarmOutputPin}, 8'h00);
        wr(8'h06, 8'h00);
        wr(8'h07, 8'hff);
        rd(8'h07, 8'h00);
        chk({7'h0, alarmOutputPin}, 8'h00);
        rdPtr = 8'h02;
        cyc(2);
        rd(8'h07, 8'h00);
        oneApartAlarmOn = 1'b1;
        twoApartAlarmOn = 1'b1;
        cyc(2);
        rd(8'h07, 8'h03);
        rdPtr = 8'h04;
        wr(8'h07, 8'h00);
        cyc(2);
        rd(8'h07, 8'h02);
        rdPtr = 8'h10;
        oneApartAlarmOn = 1'b0;
        twoApartAlarmOn = 1'b0;
        wr(8'h07, 8'h00);
        samp(8'hff);
        rd(8'h08, 8'h00);
        patternCheckOn = 1'b1;
        for (int i = 0; i < 4; i++) samp(wd(pi));
        samp(wd(pi) ^ 8'h0f);
        rd(8'h08, 8'h0f);
        rd(8'h07, 8'h08);
        autoClearAfterGoodRun = 1'b1;
        repeat (63) samp(wd(pi));
        rd(8'h07, 8'h08);
        samp(wd(pi));
        rd(8'h07, 8'h00);
        rd(8'h08, 8'h00);
        repeat (10) samp(wd(pi));
        samp(wd(pi) ^ 8'h01);
        repeat (63) samp(wd(pi));
        rd(8'h07, 8'h08);
        samp(wd(pi));
        rd(8'h07, 8'h00);
        tally_and_finish;
    end
endmodule // acpc_regs_tb
